// ===== inc/nvac_pkg.sv
// Package for the data nonvolatile access controller: map, fields, timing
package nvac_pkg;
    // Register byte offsets on the register bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_UNLOCK = 8'h04;
    localparam logic [7:0] OFS_BYTE = 8'h08;
    localparam logic [7:0] OFS_IDX_LO = 8'h0C;
    localparam logic [7:0] OFS_IDX_HI = 8'h10;
    localparam logic [7:0] OFS_FLAGS6 = 8'h14;
    localparam logic [7:0] OFS_MASKS6 = 8'h18;
    localparam logic [7:0] OFS_PRIO6 = 8'h1C;
    // nv_control field positions
    localparam int CTL_FETCH = 0;
    localparam int CTL_START = 1;
    localparam int CTL_PEN = 2;
    localparam int CTL_ABORT = 3;
    localparam int CTL_ROWERASE = 4;
    localparam int CTL_CFG = 6;
    localparam int CTL_FLASH = 7;
    // Bit 4 of the flag, mask and priority registers
    localparam int DONE_BIT = 4;
    // Unlock keys
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    // Array geometry
    localparam int ADDR_W = 10;
    localparam int DEPTH = 1024;
    // Default timing counts in system clock cycles
    localparam int WRITE_CYCLES_DEF = 1000;
    localparam int PWRT_CYCLES_DEF = 1000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        NVAC_UL_IDLE = 2'b00,
        NVAC_UL_GOT1 = 2'b01,
        NVAC_UL_ARMED = 2'b10
    } nvac_unlock_e;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } nvac_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } nvac_axi_rsp_s;
endpackage : nvac_pkg

// ===== rtl/nvac_top.sv
// Data nonvolatile array access controller with AXI4-Lite register slave
`timescale 1ns/1ps

// Functional notes
// - A 1024-byte array reached only through registers, byte read and write.
// - Ten-bit address from index pair; upper six high-index bits ignored.
// - A byte write erases then stores, timed by an internal counter.
// - flash_space_select 0 targets data array, 1 targets program flash.
// - config_space_select 1 targets configuration space over the other select.
// - Erase or write allowed only with program_enable_bit set; clear after power-up.
// - aborted_cycle_flag shows a premature end or improper attempt; 0 on completion.
// - An abort leaves both space selects untouched.
// - cycle_start_bit starts a cycle; writing 0 ignored; cleared at completion.
// - nv_done_flag set on completion; only software or a reset clears it.
// - fetch_strobe set by software, self-clears after one cycle; blocked off data space.
// - unlock_port stores nothing and reads zero.
// - nv_byte holds fetched byte one cycle later until next read or write.
// - row_erase_select makes the next start a row erase, cleared on completion.
// - Start only after 0x55 then 0xAA to unlock_port, for every byte.
// - Start needs program_enable_bit set by an earlier access.
// - While a cycle runs, control, index and byte writes are ignored.
// - No writes during the power-up timer after power-on.
module nvac_top #(
    parameter int WRITE_CYCLES = nvac_pkg::WRITE_CYCLES_DEF,
    parameter int PWRT_CYCLES = nvac_pkg::PWRT_CYCLES_DEF
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic power_on_i, // Qualifies rst_i as a power-on reset
    input wire nvac_pkg::nvac_axi_req_s axi_req_i, // Bus requests
    output nvac_pkg::nvac_axi_rsp_s axi_rsp_o, // Bus answers
    output logic busy_o, // Self-timed cycle running
    output logic nv_done_o, // Completion flag level
    output logic pwrt_active_o // Power-up write block active
);
    logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;
    logic aw_got_reg, w_got_reg, strb0_reg;
    logic [7:0] awaddr_reg, wbyte_reg;
    logic flash_reg, cfg_reg, rowerase_reg, aborted_reg, pen_reg;
    logic start_reg, fetch_reg, done_reg, mask_reg, prio_reg;
    logic [7:0] nv_byte_reg, idx_lo_reg;
    logic [1:0] idx_hi_reg;
    logic [31:0] cnt_reg;
    logic [31:0] pwrt_cnt_reg;
    logic pwrt_done_reg, pwrt_active_reg;
    nvac_pkg::nvac_unlock_e ul_reg;
    logic [7:0] mem [0:nvac_pkg::DEPTH-1];
    logic [nvac_pkg::ADDR_W-1:0] addr_w;
    logic aw_take, w_take, ar_take, wr_fire, aw_got_next, w_got_next;
    logic rvalid_next, wr_mapped, rd_mapped, wr_ok, ctl_wr;
    logic start_ok, improper, cycle_end, data_target;
    logic [7:0] rd_mux;

    assign addr_w = {idx_hi_reg, idx_lo_reg};
    assign aw_take = axi_req_i.awvalid & awready_reg;
    assign w_take = axi_req_i.wvalid & wready_reg;
    assign ar_take = axi_req_i.arvalid & arready_reg;
    assign wr_fire = aw_got_reg & w_got_reg & ~bvalid_reg;
    assign aw_got_next = (aw_got_reg | aw_take) & ~wr_fire;
    assign w_got_next = (w_got_reg | w_take) & ~wr_fire;
    assign rvalid_next = ar_take | (rvalid_reg & ~axi_req_i.rready);
    assign wr_mapped = awaddr_reg[7:5] == 3'b000 && awaddr_reg[1:0] == 2'b00;
    assign rd_mapped = axi_req_i.araddr[7:5] == 3'b000
        && axi_req_i.araddr[1:0] == 2'b00;
    assign wr_ok = wr_fire & wr_mapped & strb0_reg;
    assign ctl_wr = wr_ok && awaddr_reg == nvac_pkg::OFS_CTRL && !start_reg;
    assign start_ok = pen_reg && ul_reg == nvac_pkg::NVAC_UL_ARMED
        && pwrt_done_reg;
    assign improper = ctl_wr && wbyte_reg[nvac_pkg::CTL_START] && !start_ok;
    assign cycle_end = start_reg && cnt_reg == 32'(WRITE_CYCLES - 1);
    assign data_target = !flash_reg && !cfg_reg;

    assign axi_rsp_o = {awready_reg, wready_reg, bvalid_reg, bresp_reg,
        arready_reg, rvalid_reg, rdata_reg, rresp_reg};
    assign busy_o = start_reg;
    assign nv_done_o = done_reg;
    assign pwrt_active_o = pwrt_active_reg;

    // Write address and data may arrive in either order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            awaddr_reg <= 8'h00;
            wbyte_reg <= 8'h00;
            strb0_reg <= 1'b0;
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg <= w_got_next;
            awready_reg <= ~aw_got_next;
            wready_reg <= ~w_got_next;
            if (aw_take) begin
                awaddr_reg <= axi_req_i.awaddr;
            end
            if (w_take) begin
                wbyte_reg <= axi_req_i.wdata[7:0];
                strb0_reg <= axi_req_i.wstrb[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= nvac_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_mapped ? nvac_pkg::RESP_OKAY
                : nvac_pkg::RESP_SLVERR;
        end else if (axi_req_i.bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        case (axi_req_i.araddr)
            nvac_pkg::OFS_CTRL: rd_mux = {flash_reg, cfg_reg, 1'b0,
                rowerase_reg, aborted_reg, pen_reg, start_reg, fetch_reg};
            nvac_pkg::OFS_UNLOCK: rd_mux = 8'h00;
            nvac_pkg::OFS_BYTE: rd_mux = nv_byte_reg;
            nvac_pkg::OFS_IDX_LO: rd_mux = idx_lo_reg;
            nvac_pkg::OFS_IDX_HI: rd_mux = {6'b00_0000, idx_hi_reg};
            nvac_pkg::OFS_FLAGS6: rd_mux = {3'b000, done_reg, 4'h0};
            nvac_pkg::OFS_MASKS6: rd_mux = {3'b000, mask_reg, 4'h0};
            nvac_pkg::OFS_PRIO6: rd_mux = {3'b000, prio_reg, 4'h0};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data answers the edge after the address is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= nvac_pkg::RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            arready_reg <= ~rvalid_next;
            if (ar_take) begin
                rdata_reg <= {24'h00_0000, rd_mapped ? rd_mux : 8'h00};
                rresp_reg <= rd_mapped ? nvac_pkg::RESP_OKAY
                    : nvac_pkg::RESP_SLVERR;
            end
        end
    end

    // Any write other than the next key drops the unlock sequence; reads leave it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ul_reg <= nvac_pkg::NVAC_UL_IDLE;
        end else if (wr_fire) begin
            if (wr_ok && awaddr_reg == nvac_pkg::OFS_UNLOCK
                && wbyte_reg == nvac_pkg::KEY_FIRST) begin
                ul_reg <= nvac_pkg::NVAC_UL_GOT1;
            end else if (wr_ok && awaddr_reg == nvac_pkg::OFS_UNLOCK
                && wbyte_reg == nvac_pkg::KEY_SECOND
                && ul_reg == nvac_pkg::NVAC_UL_GOT1) begin
                ul_reg <= nvac_pkg::NVAC_UL_ARMED;
            end else begin
                ul_reg <= nvac_pkg::NVAC_UL_IDLE;
            end
        end
    end

    // Power-up timer restarts only on a power-on reset
    always_ff @(posedge clk_i) begin
        if (rst_i && power_on_i) begin
            pwrt_cnt_reg <= 32'h0000_0000;
            pwrt_done_reg <= 1'b0;
            pwrt_active_reg <= 1'b1;
        end else if (!pwrt_done_reg) begin
            pwrt_cnt_reg <= pwrt_cnt_reg + 32'h0000_0001;
            pwrt_done_reg <= pwrt_cnt_reg == 32'(PWRT_CYCLES - 1);
            pwrt_active_reg <= pwrt_cnt_reg != 32'(PWRT_CYCLES - 1);
        end
    end

    // Control bits; frozen while a cycle runs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_reg <= power_on_i ? 1'b0 : flash_reg;
            cfg_reg <= power_on_i ? 1'b0 : cfg_reg;
            rowerase_reg <= 1'b0;
            pen_reg <= 1'b0;
            start_reg <= 1'b0;
            fetch_reg <= 1'b0;
        end else begin
            fetch_reg <= 1'b0;
            if (cycle_end) begin
                start_reg <= 1'b0;
                rowerase_reg <= 1'b0;
            end
            if (ctl_wr) begin
                flash_reg <= wbyte_reg[nvac_pkg::CTL_FLASH];
                cfg_reg <= wbyte_reg[nvac_pkg::CTL_CFG];
                rowerase_reg <= wbyte_reg[nvac_pkg::CTL_ROWERASE];
                pen_reg <= wbyte_reg[nvac_pkg::CTL_PEN];
                start_reg <= wbyte_reg[nvac_pkg::CTL_START] && start_ok;
                fetch_reg <= wbyte_reg[nvac_pkg::CTL_FETCH]
                    && !wbyte_reg[nvac_pkg::CTL_FLASH]
                    && !wbyte_reg[nvac_pkg::CTL_CFG];
            end
        end
    end

    // Abort flag survives non-power-on resets; space selects untouched
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aborted_reg <= power_on_i ? 1'b0
                : (aborted_reg | start_reg);
        end else if (improper) begin
            aborted_reg <= 1'b1;
        end else if (cycle_end) begin
            aborted_reg <= 1'b0;
        end else if (ctl_wr) begin
            aborted_reg <= wbyte_reg[nvac_pkg::CTL_ABORT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 32'h0000_0000;
        end else if (start_reg && !cycle_end) begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end else begin
            cnt_reg <= 32'h0000_0000;
        end
    end

    // Program flash and configuration cycles are timed but store nothing here
    always_ff @(posedge clk_i) begin
        if (cycle_end && data_target && !rst_i) begin
            mem[addr_w] <= nv_byte_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nv_byte_reg <= nvac_pkg::RST_BYTE;
            idx_lo_reg <= 8'h00;
            idx_hi_reg <= 2'b00;
        end else if (fetch_reg) begin
            nv_byte_reg <= mem[addr_w];
        end else if (wr_ok && !start_reg) begin
            if (awaddr_reg == nvac_pkg::OFS_BYTE) begin
                nv_byte_reg <= wbyte_reg;
            end
            if (awaddr_reg == nvac_pkg::OFS_IDX_LO) begin
                idx_lo_reg <= wbyte_reg;
            end
            if (awaddr_reg == nvac_pkg::OFS_IDX_HI) begin
                idx_hi_reg <= wbyte_reg[1:0];
            end
        end
    end

    // Completion set wins over a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
            mask_reg <= 1'b0;
            prio_reg <= 1'b0;
        end else begin
            if (cycle_end) begin
                done_reg <= 1'b1;
            end else if (wr_ok && awaddr_reg == nvac_pkg::OFS_FLAGS6) begin
                done_reg <= wbyte_reg[nvac_pkg::DONE_BIT];
            end
            if (wr_ok && awaddr_reg == nvac_pkg::OFS_MASKS6) begin
                mask_reg <= wbyte_reg[nvac_pkg::DONE_BIT];
            end
            if (wr_ok && awaddr_reg == nvac_pkg::OFS_PRIO6) begin
                prio_reg <= wbyte_reg[nvac_pkg::DONE_BIT];
            end
        end
    end

    logic [7:0] mem_q;
    assign mem_q = mem[addr_w];

    property p_start_guard;
        @(posedge clk_i) disable iff (rst_i)
        (ctl_wr && !start_ok) |=> !start_reg;
    endproperty
    a_start_guard: assert property (p_start_guard)
        else $error("Cycle started without unlock or enable");

    property p_cycle_end;
        @(posedge clk_i) disable iff (rst_i)
        cycle_end |=> !start_reg && done_reg && !aborted_reg;
    endproperty
    a_cycle_end: assert property (p_cycle_end)
        else $error("Cycle end did not clear start or set done");

    property p_cycle_len;
        @(posedge clk_i) disable iff (rst_i)
        (start_reg && !cycle_end) |-> cnt_reg < 32'(WRITE_CYCLES - 1);
    endproperty
    a_cycle_len: assert property (p_cycle_len)
        else $error("Cycle counter passed its length");

    property p_fetch;
        @(posedge clk_i) disable iff (rst_i)
        fetch_reg |-> !flash_reg && !cfg_reg ##1 !fetch_reg;
    endproperty
    a_fetch: assert property (p_fetch)
        else $error("Fetch strobe wrong space or not one cycle");

    property p_fetch_data;
        @(posedge clk_i) disable iff (rst_i)
        fetch_reg |=> nv_byte_reg == $past(mem_q);
    endproperty
    a_fetch_data: assert property (p_fetch_data)
        else $error("Fetched byte not presented");

    property p_frozen;
        @(posedge clk_i) disable iff (rst_i)
        (start_reg ##1 start_reg) |-> $stable(addr_w) && $stable(nv_byte_reg)
            && $stable(pen_reg) && $stable(flash_reg);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("Registers changed during a cycle");

    property p_pwrt;
        @(posedge clk_i) disable iff (rst_i)
        !pwrt_done_reg |-> !start_reg;
    endproperty
    a_pwrt: assert property (p_pwrt)
        else $error("Write ran during power-up timer");

    property p_unlock_read;
        @(posedge clk_i) disable iff (rst_i)
        (ar_take && axi_req_i.araddr == nvac_pkg::OFS_UNLOCK)
            |=> rdata_reg == 32'h0000_0000;
    endproperty
    a_unlock_read: assert property (p_unlock_read)
        else $error("Unlock port read not zero");

    property p_improper;
        @(posedge clk_i) disable iff (rst_i)
        improper |=> aborted_reg && !start_reg;
    endproperty
    a_improper: assert property (p_improper)
        else $error("Improper attempt not flagged");

    property p_store;
        @(posedge clk_i) disable iff (rst_i)
        (cycle_end && data_target) |=> mem_q == $past(nv_byte_reg)
            && !rowerase_reg;
    endproperty
    a_store: assert property (p_store)
        else $error("Completed byte not stored");

    c_write: cover property (@(posedge clk_i) disable iff (rst_i)
        cycle_end && data_target);
    c_read: cover property (@(posedge clk_i) disable iff (rst_i) fetch_reg);
    c_improper: cover property (@(posedge clk_i) disable iff (rst_i)
        improper);
    c_slverr: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_fire && !wr_mapped);
endmodule : nvac_top

// ===== dv/tb_top.sv
// Self-checking bench for the data nonvolatile access controller
`timescale 1ns/1ps
module tb_top;
    localparam int WC = 40;
    localparam int PW = 40;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic power_on_i = 1'b1;
    nvac_pkg::nvac_axi_req_s req = '0;
    nvac_pkg::nvac_axi_rsp_s rsp;
    logic busy_o;
    logic nv_done_o;
    logic pwrt_active_o;
    logic [3:0] strb = 4'hF;
    logic [31:0] rd;
    logic [1:0] rs;
    int fails = 0;
    int num_checks = 0;
    int n;

    always #10 clk_i = ~clk_i;

    nvac_top #(.WRITE_CYCLES(WC), .PWRT_CYCLES(PW)) dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .power_on_i(power_on_i),
        .axi_req_i(req),
        .axi_rsp_o(rsp),
        .busy_o(busy_o),
        .nv_done_o(nv_done_o),
        .pwrt_active_o(pwrt_active_o)
    );

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h00_0000, d};
        req.wstrb <= strb;
        req.bready <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1 && k < 100);
        rs = rsp.bresp;
        req.bready <= 1'b0;
        if (k >= 100) fails++;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        int k;
        k = 0;
        @(posedge clk_i);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clk_i);
            k++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1 && k < 100);
        rd = rsp.rdata;
        rs = rsp.rresp;
        req.rready <= 1'b0;
        if (k >= 100) fails++;
    endtask : rdr

    task automatic rchk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
        rdr(a);
        chk(nm, e, rd & m);
    endtask : rchk

    task automatic do_reset(input logic po);
        @(posedge clk_i);
        rst_i <= 1'b1;
        power_on_i <= po;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        power_on_i <= 1'b0;
    endtask : do_reset

    // Enable first, then the two keys, then start with enable kept
    task automatic arm(input logic [7:0] sel);
        wr(nvac_pkg::OFS_CTRL, sel | 8'h04);
        wr(nvac_pkg::OFS_UNLOCK, nvac_pkg::KEY_FIRST);
        wr(nvac_pkg::OFS_UNLOCK, nvac_pkg::KEY_SECOND);
        wr(nvac_pkg::OFS_CTRL, sel | 8'h06);
    endtask : arm

    task automatic busy_chk(input string nm, input logic e);
        @(negedge clk_i);
        chk(nm, e, busy_o);
    endtask : busy_chk

    task automatic wait_idle();
        n = 0;
        while (busy_o === 1'b1 && n < 200) begin
            @(negedge clk_i);
            n++;
        end
    endtask : wait_idle

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        summarize();
    end

    initial begin
        do_reset(1'b1);
        @(negedge clk_i);
        chk("pwrt_active", 1'b1, pwrt_active_o);
        rchk("ctrl_por", nvac_pkg::OFS_CTRL, 32'h0000_000F, 0);
        // Start while the power-up timer still runs
        arm(8'h00);
        busy_chk("busy_pwrt", 1'b0);
        rchk("abort_pwrt", nvac_pkg::OFS_CTRL, 32'h0000_0008, 8);
        n = 0;
        while (pwrt_active_o !== 1'b0 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        chk("pwrt_done", 1'b0, pwrt_active_o);
        wr(8'h20, 8'h55);
        chk("bresp_unmapped", nvac_pkg::RESP_SLVERR, rs);
        rdr(8'h20);
        chk("rresp_unmapped", nvac_pkg::RESP_SLVERR, rs);
        chk("rdata_unmapped", 0, rd);
        rchk("unlock_read", nvac_pkg::OFS_UNLOCK, 32'hFFFF_FFFF, 0);
        wr(nvac_pkg::OFS_MASKS6, 8'hFF);
        rchk("masks6", nvac_pkg::OFS_MASKS6, 32'hFFFF_FFFF, 32'h0000_0010);
        wr(nvac_pkg::OFS_PRIO6, 8'hFF);
        rchk("prio6", nvac_pkg::OFS_PRIO6, 32'hFFFF_FFFF, 32'h0000_0010);
        // Enable and start in one access must not start
        wr(nvac_pkg::OFS_CTRL, 8'h00);
        wr(nvac_pkg::OFS_UNLOCK, nvac_pkg::KEY_FIRST);
        wr(nvac_pkg::OFS_UNLOCK, nvac_pkg::KEY_SECOND);
        wr(nvac_pkg::OFS_CTRL, 8'h06);
        busy_chk("busy_same_access", 1'b0);
        // Stray write between the keys breaks the arming
        wr(nvac_pkg::OFS_CTRL, 8'h04);
        wr(nvac_pkg::OFS_UNLOCK, nvac_pkg::KEY_FIRST);
        wr(8'h20, 8'h00);
        wr(nvac_pkg::OFS_UNLOCK, nvac_pkg::KEY_SECOND);
        wr(nvac_pkg::OFS_CTRL, 8'h06);
        busy_chk("busy_broken_keys", 1'b0);
        // Data write to 0x321, upper index bits set to prove they are dropped
        wr(nvac_pkg::OFS_IDX_HI, 8'hFF);
        wr(nvac_pkg::OFS_IDX_LO, 8'h21);
        wr(nvac_pkg::OFS_BYTE, 8'hA5);
        arm(8'h00);
        busy_chk("busy_write", 1'b1);
        wr(nvac_pkg::OFS_BYTE, 8'h11);
        wr(nvac_pkg::OFS_IDX_LO, 8'h00);
        rchk("start_held", nvac_pkg::OFS_CTRL, 32'h0000_0002, 2);
        wait_idle();
        chk("cycle_len", 1'b1, n >= 18 && n <= 41);
        chk("done_level", 1'b1, nv_done_o);
        rchk("flags6_set", nvac_pkg::OFS_FLAGS6, 32'hFF, 32'h10);
        rchk("ctrl_end", nvac_pkg::OFS_CTRL, 32'h0000_000A, 0);
        wr(nvac_pkg::OFS_FLAGS6, 8'h00);
        rchk("flags6_clr", nvac_pkg::OFS_FLAGS6, 32'hFF, 0);
        // Keys are needed again for the next byte
        wr(nvac_pkg::OFS_CTRL, 8'h06);
        busy_chk("busy_no_keys", 1'b0);
        wr(nvac_pkg::OFS_IDX_HI, 8'h03);
        wr(nvac_pkg::OFS_BYTE, 8'h00);
        wr(nvac_pkg::OFS_CTRL, 8'h01);
        rchk("fetch", nvac_pkg::OFS_BYTE, 32'hFF, 32'hA5);
        rchk("fetch_hold", nvac_pkg::OFS_BYTE, 32'hFF, 32'hA5);
        rchk("strobe_clr", nvac_pkg::OFS_CTRL, 32'h0000_0001, 0);
        wr(nvac_pkg::OFS_BYTE, 8'h5A);
        wr(nvac_pkg::OFS_CTRL, 8'h81);
        rchk("fetch_flash", nvac_pkg::OFS_BYTE, 32'hFF, 32'h5A);
        wr(nvac_pkg::OFS_CTRL, 8'h41);
        rchk("fetch_cfg", nvac_pkg::OFS_BYTE, 32'hFF, 32'h5A);
        strb = 4'hE;
        wr(nvac_pkg::OFS_BYTE, 8'h77);
        strb = 4'hF;
        rchk("byte_strobe", nvac_pkg::OFS_BYTE, 32'hFF, 32'h5A);
        // Program flash row erase must leave the data array alone
        wr(nvac_pkg::OFS_BYTE, 8'h3C);
        arm(8'h90);
        busy_chk("busy_flash", 1'b1);
        wait_idle();
        rchk("row_clr", nvac_pkg::OFS_CTRL, 32'h0000_0090, 32'h80);
        wr(nvac_pkg::OFS_CTRL, 8'h00);
        wr(nvac_pkg::OFS_CTRL, 8'h01);
        rchk("flash_no_store", nvac_pkg::OFS_BYTE, 32'hFF, 32'hA5);
        // Warm reset in the middle of a configuration cycle
        wr(nvac_pkg::OFS_BYTE, 8'hC3);
        arm(8'h40);
        busy_chk("busy_cfg", 1'b1);
        do_reset(1'b0);
        busy_chk("busy_after_rst", 1'b0);
        rchk("ctrl_abort", nvac_pkg::OFS_CTRL, 32'hCA, 32'h48);
        wr(nvac_pkg::OFS_CTRL, 8'h00);
        // Index pair set back to 0x321 to show the configuration cycle stored nothing
        wr(nvac_pkg::OFS_IDX_HI, 8'h03);
        wr(nvac_pkg::OFS_IDX_LO, 8'h21);
        wr(nvac_pkg::OFS_CTRL, 8'h01);
        rchk("cfg_no_store", nvac_pkg::OFS_BYTE, 32'hFF, 32'hA5);
        summarize();
    end
endmodule : tb_top
